/* File: rtl/bsfc_map.vh */
// Purpose: register offsets, field positions and timing counts of the
//          boot sector flash controller
// Assumes: 25 MHz clk_sys, AHB-Lite word registers
// Notes:   included by bare name
`ifndef BSFC_MAP_VH
`define BSFC_MAP_VH

// ----------------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------------
`define BSFC_REG_CTRL    8'h00
`define BSFC_REG_ADDR    8'h04
`define BSFC_REG_WDATA   8'h08
`define BSFC_REG_STATUS  8'h0C
`define BSFC_REG_RDATA   8'h10

// ----------------------------------------------------------------------
// control fields
// ----------------------------------------------------------------------
`define BSFC_CTRL_GO     0
`define BSFC_CTRL_OP_LO  1
`define BSFC_CTRL_OP_HI  3
`define BSFC_CTRL_BYTE   4
`define BSFC_CTRL_BYPASS 5
`define BSFC_CTRL_STBY   6
`define BSFC_CTRL_RST    7

// operation codes
`define BSFC_OP_READ     3'h0
`define BSFC_OP_PROG     3'h1
`define BSFC_OP_SECT     3'h2
`define BSFC_OP_CHIP     3'h3
`define BSFC_OP_SUSP     3'h4
`define BSFC_OP_RESUME   3'h5
`define BSFC_OP_RAW      3'h6
`define BSFC_OP_UBEXIT   3'h7

// ----------------------------------------------------------------------
// status fields
// ----------------------------------------------------------------------
`define BSFC_ST_BUSY     0
`define BSFC_ST_DONE     1
`define BSFC_ST_FLASH_RB 2
`define BSFC_ST_BYPASS   3
`define BSFC_ST_TMO      4

// ----------------------------------------------------------------------
// flash command codes and unlock addresses (word mode)
// ----------------------------------------------------------------------
`define BSFC_UNL_A1      20'h00555
`define BSFC_UNL_A2      20'h002AA
`define BSFC_UNL_D1      8'hAA
`define BSFC_UNL_D2      8'h55
`define BSFC_CMD_PROG    8'hA0
`define BSFC_CMD_ERASE   8'h80
`define BSFC_CMD_CHIP    8'h10
`define BSFC_CMD_SECT    8'h30
`define BSFC_CMD_SUSP    8'hB0
`define BSFC_CMD_BYPASS  8'h20
`define BSFC_CMD_UB_X1   8'h90
`define BSFC_CMD_UB_X2   8'h00
`define BSFC_CMD_RESET   8'hF0

// ----------------------------------------------------------------------
// timing: bus phase and reset pulse, in ns
// ----------------------------------------------------------------------
`define BSFC_CLK_NS      40
`define BSFC_PHASE_NS    120
`define BSFC_PHASE_CYC   ((`BSFC_PHASE_NS + `BSFC_CLK_NS - 1) / `BSFC_CLK_NS)
`define BSFC_RSTP_NS     500
`define BSFC_RSTP_CYC    ((`BSFC_RSTP_NS + `BSFC_CLK_NS - 1) / `BSFC_CLK_NS)

`endif

/* File: rtl/bsfc_bus_cycle.v */
// Purpose: one asynchronous flash bus cycle (read or write) on the pins
// Assumes: strobes active low, phase length in clk_sys cycles
// Notes:   data_bus output enable high only during write cycles
`timescale 1ns/10ps

module bsfc_bus_cycle #(
  parameter PHASE = 3
) (
  input  wire        clk_sys,
  input  wire        sys_rst,
  input  wire        start,
  input  wire        wr,
  input  wire [19:0] addr,
  input  wire [15:0] wdata,
  output wire        done,
  output reg  [15:0] rdata_q,
  output reg  [19:0] fl_addr_q,
  output reg         fl_ce_n_q,
  output reg         fl_we_n_q,
  output reg         fl_oe_n_q,
  output reg  [15:0] fl_dq_out_q,
  output reg         fl_dq_oe_q,
  input  wire [15:0] fl_dq_in
);

  localparam ST_IDLE  = 2'd0;
  localparam ST_SETUP = 2'd1;
  localparam ST_PULSE = 2'd2;
  localparam ST_HOLD  = 2'd3;

  reg [1:0] state_q;
  reg [7:0] cnt_q;
  reg       done_q;

  assign done = done_q;

  // ----------------------------------------------------------------------
  // setup, strobe and hold phases, each PHASE cycles
  // ----------------------------------------------------------------------
  always @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state_q     <= ST_IDLE;
      cnt_q       <= 8'h00;
      done_q      <= 1'b0;
      rdata_q     <= 16'h0000;
      fl_addr_q   <= 20'h00000;
      fl_ce_n_q   <= 1'b1;
      fl_we_n_q   <= 1'b1;
      fl_oe_n_q   <= 1'b1;
      fl_dq_out_q <= 16'h0000;
      fl_dq_oe_q  <= 1'b0;
    end
    else
    begin
      done_q <= 1'b0;
      case (state_q)
        ST_IDLE:
          if (start)
          begin
            fl_addr_q   <= addr;
            fl_dq_out_q <= wdata;
            fl_dq_oe_q  <= wr;
            fl_ce_n_q   <= 1'b0;
            cnt_q       <= 8'h00;
            state_q     <= ST_SETUP;
          end
        ST_SETUP:
          if (cnt_q == PHASE[7:0] - 8'h01)
          begin
            cnt_q     <= 8'h00;
            fl_we_n_q <= ~wr;
            fl_oe_n_q <= wr;
            state_q   <= ST_PULSE;
          end
          else
            cnt_q <= cnt_q + 8'h01;
        ST_PULSE:
          if (cnt_q == PHASE[7:0] - 8'h01)
          begin
            cnt_q     <= 8'h00;
            rdata_q   <= fl_dq_in;
            fl_we_n_q <= 1'b1;
            fl_oe_n_q <= 1'b1;
            state_q   <= ST_HOLD;
          end
          else
            cnt_q <= cnt_q + 8'h01;
        ST_HOLD:
          if (cnt_q == PHASE[7:0] - 8'h01)
          begin
            fl_ce_n_q  <= 1'b1;
            fl_dq_oe_q <= 1'b0;
            done_q     <= 1'b1;
            state_q    <= ST_IDLE;
          end
          else
            cnt_q <= cnt_q + 8'h01;
        default:
          state_q <= ST_IDLE;
      endcase
    end
  end

endmodule

/* File: rtl/bsfc_ctrl.v */
// Purpose: host-side controller of a boot sector NOR flash; takes orders
//          over AHB-Lite and issues command sequences on the flash pins
// Assumes: single clock clk_sys at 25 MHz, flash pins synchronous
// Notes:   completion found by toggle polling of the status bits
//
// Added by the designer: the register offsets and the AHB-Lite register port.
`timescale 1ns/10ps
`include "bsfc_map.vh"

module bsfc_ctrl #(
  parameter PHASE    = `BSFC_PHASE_CYC,
  parameter RST_CYC  = `BSFC_RSTP_CYC,
  parameter POLL_MAX = 32'd50000000
) (
  input  wire        clk_sys,
  input  wire        sys_rst,
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output wire        hreadyout,
  output wire        hresp,
  output reg  [31:0] hrdata,
  output wire [19:0] fl_addr,
  output wire        fl_byte_n,
  output wire        fl_ce_n,
  output wire        fl_we_n,
  output wire        fl_oe_n,
  output wire        fl_reset_n,
  output wire [15:0] data_bus_out,
  output wire        data_bus_oe,
  input  wire [15:0] data_bus_in,
  input  wire        completion_indicator_n
);

  localparam S_IDLE  = 3'd0;
  localparam S_ISSUE = 3'd1;
  localparam S_WAIT  = 3'd2;
  localparam S_POLL1 = 3'd3;
  localparam S_POLL2 = 3'd4;
  localparam S_RST   = 3'd5;

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  reg  [2:0]  state_q;
  reg  [2:0]  step_q;
  reg  [2:0]  nsteps_q;
  reg  [2:0]  op_q;
  reg  [19:0] addr_q;
  reg  [15:0] wdata_q;
  reg  [15:0] rdata_q;
  reg  [15:0] poll_a_q;
  reg         byte_q;
  reg         stby_q;
  reg         bypass_q;
  reg         done_q;
  reg         tmo_q;
  reg         reset_n_q;
  reg  [31:0] cnt_q;
  reg         dph_q;
  reg         dwr_q;
  reg  [7:0]  daddr_q;

  reg         cyc_start;
  reg         cyc_wr;
  reg  [19:0] cyc_addr;
  reg  [15:0] cyc_wdata;
  wire        cyc_done;
  wire [15:0] cyc_rdata;
  wire        cyc_ce_n;

  wire busy = (state_q != S_IDLE);
  wire go   = dph_q & dwr_q & (daddr_q == `BSFC_REG_CTRL) &
              hwdata[`BSFC_CTRL_GO] & ~busy;

  // ----------------------------------------------------------------------
  // AHB-Lite slave: zero wait states, always OKAY
  // ----------------------------------------------------------------------
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  always @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      dph_q   <= 1'b0;
      dwr_q   <= 1'b0;
      daddr_q <= 8'h00;
    end
    else if (hready)
    begin
      dph_q   <= hsel & htrans[1];
      dwr_q   <= hwrite;
      daddr_q <= haddr[7:0];
    end
  end

  // read mux, unmapped reads give zero
  always @*
  begin
    case (daddr_q)
      `BSFC_REG_CTRL:   hrdata = {24'h000000, 1'b0, stby_q, bypass_q,
                                  byte_q, op_q, 1'b0};
      `BSFC_REG_ADDR:   hrdata = {12'h000, addr_q};
      `BSFC_REG_WDATA:  hrdata = {16'h0000, wdata_q};
      `BSFC_REG_STATUS: hrdata = {27'h0000000, tmo_q, bypass_q,
                                  completion_indicator_n, done_q, busy};
      `BSFC_REG_RDATA:  hrdata = {16'h0000, rdata_q};
      default:          hrdata = 32'h00000000;
    endcase
  end

  // ----------------------------------------------------------------------
  // command sequence table: step -> address/data of each write
  // ----------------------------------------------------------------------
  always @*
  begin
    cyc_wr    = 1'b1;
    cyc_addr  = `BSFC_UNL_A1;
    cyc_wdata = {8'h00, `BSFC_UNL_D1};
    case (op_q)
      `BSFC_OP_READ:
      begin
        cyc_wr   = 1'b0;
        cyc_addr = addr_q;
      end
      `BSFC_OP_RAW:
      begin
        cyc_addr  = addr_q;
        cyc_wdata = wdata_q;
      end
      `BSFC_OP_SUSP, `BSFC_OP_RESUME:
      begin
        cyc_addr  = addr_q;
        cyc_wdata = {8'h00, (op_q == `BSFC_OP_SUSP) ?
                     `BSFC_CMD_SUSP : `BSFC_CMD_SECT};
      end
      `BSFC_OP_UBEXIT:
        cyc_wdata = {8'h00, (step_q == 3'd0) ?
                     `BSFC_CMD_UB_X1 : `BSFC_CMD_UB_X2};
      default:
      begin
        // unlock writes, then command, then the target write
        case (step_q)
          3'd0: cyc_wdata = {8'h00, `BSFC_UNL_D1};
          3'd1:
          begin
            cyc_addr  = `BSFC_UNL_A2;
            cyc_wdata = {8'h00, `BSFC_UNL_D2};
          end
          3'd2: cyc_wdata = {8'h00, (op_q == `BSFC_OP_PROG) ?
                             `BSFC_CMD_PROG : `BSFC_CMD_ERASE};
          3'd3: cyc_wdata = {8'h00, `BSFC_UNL_D1};
          3'd4:
          begin
            cyc_addr  = `BSFC_UNL_A2;
            cyc_wdata = {8'h00, `BSFC_UNL_D2};
          end
          default:
          begin
            cyc_addr  = addr_q;
            cyc_wdata = {8'h00, (op_q == `BSFC_OP_CHIP) ?
                         `BSFC_CMD_CHIP : `BSFC_CMD_SECT};
          end
        endcase
        if (op_q == `BSFC_OP_PROG && step_q == 3'd3)
        begin
          cyc_addr  = addr_q;
          cyc_wdata = wdata_q;
        end
        if (op_q == `BSFC_OP_PROG && bypass_q)
        begin
          cyc_addr  = addr_q;
          cyc_wdata = (step_q == 3'd0) ? {8'h00, `BSFC_CMD_PROG}
                                       : wdata_q;
        end
      end
    endcase
    if (state_q == S_POLL1 || state_q == S_POLL2)
    begin
      cyc_wr   = 1'b0;
      cyc_addr = addr_q;
    end
    // byte mode carries data on low lanes only
    if (byte_q)
      cyc_wdata = {8'h00, cyc_wdata[7:0]};
  end

  // sequence length per operation
  function [2:0] seq_len;
    input [2:0] op;
    input       byp;
    begin
      case (op)
        `BSFC_OP_PROG:   seq_len = byp ? 3'd2 : 3'd4;
        `BSFC_OP_SECT,
        `BSFC_OP_CHIP:   seq_len = 3'd6;
        `BSFC_OP_UBEXIT: seq_len = 3'd2;
        default:         seq_len = 3'd1;
      endcase
    end
  endfunction

  // ----------------------------------------------------------------------
  // main sequencer
  // ----------------------------------------------------------------------
  always @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state_q   <= S_IDLE;
      step_q    <= 3'd0;
      nsteps_q  <= 3'd1;
      op_q      <= `BSFC_OP_READ;
      addr_q    <= 20'h00000;
      wdata_q   <= 16'h0000;
      rdata_q   <= 16'h0000;
      poll_a_q  <= 16'h0000;
      byte_q    <= 1'b0;
      stby_q    <= 1'b0;
      bypass_q  <= 1'b0;
      done_q    <= 1'b0;
      tmo_q     <= 1'b0;
      reset_n_q <= 1'b1;
      cnt_q     <= 32'd0;
      cyc_start <= 1'b0;
    end
    else
    begin
      cyc_start <= 1'b0;
      if (dph_q && dwr_q && !busy)
      begin
        if (daddr_q == `BSFC_REG_ADDR)
          addr_q <= hwdata[19:0];
        if (daddr_q == `BSFC_REG_WDATA)
          wdata_q <= hwdata[15:0];
        if (daddr_q == `BSFC_REG_CTRL)
        begin
          op_q   <= hwdata[`BSFC_CTRL_OP_HI:`BSFC_CTRL_OP_LO];
          byte_q <= hwdata[`BSFC_CTRL_BYTE];
          stby_q <= hwdata[`BSFC_CTRL_STBY];
        end
      end
      case (state_q)
        S_IDLE:
          if (go && hwdata[`BSFC_CTRL_RST])
          begin
            reset_n_q <= 1'b0;
            bypass_q  <= 1'b0;
            cnt_q     <= 32'd0;
            done_q    <= 1'b0;
            state_q   <= S_RST;
          end
          else if (go)
          begin
            done_q   <= 1'b0;
            tmo_q    <= 1'b0;
            step_q   <= 3'd0;
            nsteps_q <= seq_len(hwdata[`BSFC_CTRL_OP_HI:`BSFC_CTRL_OP_LO],
                                bypass_q);
            state_q  <= S_ISSUE;
          end
        S_ISSUE:
        begin
          cyc_start <= 1'b1;
          state_q   <= S_WAIT;
        end
        S_WAIT:
          if (cyc_done)
          begin
            if (step_q != nsteps_q - 3'd1)
            begin
              step_q  <= step_q + 3'd1;
              state_q <= S_ISSUE;
            end
            else if (op_q == `BSFC_OP_PROG || op_q == `BSFC_OP_SECT ||
                     op_q == `BSFC_OP_CHIP)
            begin
              cnt_q     <= 32'd0;
              cyc_start <= 1'b1;
              state_q   <= S_POLL1;
            end
            else
            begin
              rdata_q <= cyc_rdata;
              if (op_q == `BSFC_OP_UBEXIT)
                bypass_q <= 1'b0;
              if (op_q == `BSFC_OP_RAW && wdata_q[7:0] == `BSFC_CMD_RESET)
                bypass_q <= 1'b0;
              if (op_q == `BSFC_OP_RAW && wdata_q[7:0] == `BSFC_CMD_BYPASS)
                bypass_q <= 1'b1;
              done_q  <= 1'b1;
              state_q <= S_IDLE;
            end
          end
        S_POLL1:
          if (cyc_done)
          begin
            poll_a_q  <= cyc_rdata;
            cyc_start <= 1'b1;
            state_q   <= S_POLL2;
          end
        S_POLL2:
          if (cyc_done)
          begin
            cnt_q <= cnt_q + 32'd1;
            // toggle bit steady between two reads means finished
            if (poll_a_q[6] == cyc_rdata[6])
            begin
              rdata_q <= cyc_rdata;
              done_q  <= 1'b1;
              state_q <= S_IDLE;
            end
            else if (cnt_q == POLL_MAX)
            begin
              tmo_q   <= 1'b1;
              done_q  <= 1'b1;
              state_q <= S_IDLE;
            end
            else
            begin
              cyc_start <= 1'b1;
              state_q   <= S_POLL1;
            end
          end
        S_RST:
          if (cnt_q == RST_CYC - 1)
          begin
            reset_n_q <= 1'b1;
            done_q    <= 1'b1;
            state_q   <= S_IDLE;
          end
          else
            cnt_q <= cnt_q + 32'd1;
        default:
          state_q <= S_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // pin cycle engine; chip select comes from the cycle engine alone, stby_q does not gate it
  // ----------------------------------------------------------------------
  bsfc_bus_cycle #(
    .PHASE (PHASE)
  ) u_cycle (
    .clk_sys     (clk_sys),
    .sys_rst     (sys_rst),
    .start       (cyc_start),
    .wr          (cyc_wr),
    .addr        (cyc_addr),
    .wdata       (cyc_wdata),
    .done        (cyc_done),
    .rdata_q     (cyc_rdata),
    .fl_addr_q   (fl_addr),
    .fl_ce_n_q   (cyc_ce_n),
    .fl_we_n_q   (fl_we_n),
    .fl_oe_n_q   (fl_oe_n),
    .fl_dq_out_q (data_bus_out),
    .fl_dq_oe_q  (data_bus_oe),
    .fl_dq_in    (data_bus_in)
  );

  assign fl_ce_n    = cyc_ce_n;
  assign fl_byte_n  = ~byte_q;
  assign fl_reset_n = reset_n_q;

endmodule

/* File: testbench/bsfc_ctrl_checker.sv */
// Purpose: pin protocol checks of the flash controller
// Assumes: one clock, strobes and flash reset active low
// Notes:   bound to bsfc_ctrl after the module
`timescale 1ns/10ps

module bsfc_ctrl_checker #(
  parameter PHASE   = 3,
  parameter RST_CYC = 13
) (
  input wire        clk_sys,
  input wire        sys_rst,
  input wire [19:0] fl_addr,
  input wire        fl_ce_n,
  input wire        fl_we_n,
  input wire        fl_oe_n,
  input wire        fl_reset_n,
  input wire [15:0] data_bus_out,
  input wire        data_bus_oe
);
  logic [7:0] stb_q;
  logic [7:0] rst_q;

  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  // length of the running strobe and flash reset pulses
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      stb_q <= 8'h00;
      rst_q <= 8'h00;
    end
    else
    begin
      stb_q <= (fl_we_n && fl_oe_n) ? 8'h00 : stb_q + 8'h01;
      rst_q <= fl_reset_n ? 8'h00 : rst_q + 8'h01;
    end
  end

  sequence s_setup;
    (fl_we_n && fl_oe_n) [*3] ##1 !(fl_we_n && fl_oe_n);
  endsequence
  sequence s_hold;
    !fl_ce_n [*3] ##1 fl_ce_n;
  endsequence

  AST_ONE_STROBE:
    assert property (fl_we_n || fl_oe_n)
    else $error("write and output strobes low together");
  AST_STROBE_CE:
    assert property (!(fl_we_n && fl_oe_n) |-> !fl_ce_n)
    else $error("strobe low without chip select");
  AST_NO_FIGHT:
    assert property (data_bus_oe |-> fl_oe_n)
    else $error("data driven while output strobe low");
  AST_WE_DATA:
    assert property (!fl_we_n |-> data_bus_oe)
    else $error("write strobe low with data undriven");
  AST_WE_STABLE:
    assert property (!fl_we_n && !$past(fl_we_n) |->
      $stable(fl_addr) && $stable(data_bus_out))
    else $error("address or data moved under write strobe");
  AST_SETUP:
    assert property ($fell(fl_ce_n) |-> s_setup)
    else $error("strobe setup after select wrong");
  AST_HOLD:
    assert property ($rose(fl_we_n && fl_oe_n) |-> s_hold)
    else $error("select hold after strobe wrong");
  AST_STB_WIDTH:
    assert property ($rose(fl_we_n && fl_oe_n) |-> stb_q == PHASE)
    else $error("strobe width wrong");
  AST_RST_WIDTH:
    assert property ($rose(fl_reset_n) |-> rst_q == RST_CYC)
    else $error("flash reset pulse width wrong");
  AST_RST_QUIET:
    assert property (!fl_reset_n |-> fl_ce_n && !data_bus_oe)
    else $error("bus active during flash reset");
endmodule

bind bsfc_ctrl bsfc_ctrl_checker #(.PHASE(PHASE), .RST_CYC(RST_CYC)) chk_u (
  .clk_sys(clk_sys), .sys_rst(sys_rst), .fl_addr(fl_addr),
  .fl_ce_n(fl_ce_n), .fl_we_n(fl_we_n), .fl_oe_n(fl_oe_n),
  .fl_reset_n(fl_reset_n), .data_bus_out(data_bus_out),
  .data_bus_oe(data_bus_oe));

/* File: testbench/bsfc_flash_model.sv */
// Purpose: behavioural boot sector flash on the controller pins
// Assumes: word mode unlock addresses, bottom boot sector map
// Notes:   operations last BUSY_NS; released data lines show inverse
`timescale 1ns/10ps

module bsfc_flash_model #(
  parameter int BUSY_NS = 4000
) (
  input  wire  [19:0] fl_addr,
  input  wire         fl_byte_n,
  input  wire         fl_ce_n,
  input  wire         fl_we_n,
  input  wire         fl_oe_n,
  input  wire         fl_reset_n,
  input  wire  [15:0] data_bus_out,
  output wire  [15:0] data_bus_in,
  output wire         completion_indicator_n
);
  logic [15:0] mem [logic [19:0]];
  logic [15:0] rd = 16'hFFFF;
  logic [15:0] last = 16'h0000;
  int          step = 0;
  logic        byp = 1'b0;
  logic        busy = 1'b0;
  logic        tgl = 1'b0;
  logic        pd7 = 1'b0;
  wire         drv = !fl_ce_n && !fl_oe_n && fl_reset_n;

  assign completion_indicator_n = !busy;
  assign data_bus_in[7:0] = drv ? rd[7:0] : ~last[7:0];
  assign data_bus_in[15:8] =
    (drv && fl_byte_n) ? rd[15:8] : ~last[15:8];

  // base word address of the sector holding a
  function automatic logic [19:0] sbase(input logic [19:0] a);
    if (a < 20'h04000)
      return (a < 20'h02000) ? 20'h00000 : {a[19:12], 12'h000};
    return (a < 20'h08000) ? 20'h04000 : {a[19:15], 15'h0000};
  endfunction

  // internal program or erase algorithm
  task automatic run(input int kind, input logic [19:0] a,
                     input logic [15:0] d);
    logic [19:0] ks[$];
    busy = 1'b1;
    pd7 = (kind == 0) ? ~d[7] : 1'b0;
    #(BUSY_NS);
    if (busy && kind == 0)
      mem[a] = (mem.exists(a) ? mem[a] : 16'hFFFF) & d;
    if (busy && kind == 1)
    begin
      foreach (mem[k])
        if (sbase(k) == sbase(a))
          ks.push_back(k);
      foreach (ks[i])
        mem.delete(ks[i]);
    end
    if (busy && kind == 2)
      mem.delete();
    busy = 1'b0;
  endtask

  // command decoder; unexpected writes fall back to array reads
  task automatic decode(input logic [19:0] a, input logic [15:0] d);
    int nx;
    nx = 0;
    case (step)
      0: if (a == 20'h00555 && d[7:0] == 8'hAA) nx = 1;
         else if (byp && d[7:0] == 8'hA0) nx = 3;
         else if (byp && d[7:0] == 8'h90) nx = 6;
      1: if (a == 20'h002AA && d[7:0] == 8'h55) nx = 2;
      2: if (a == 20'h00555 && d[7:0] == 8'hA0) nx = 3;
         else if (a == 20'h00555 && d[7:0] == 8'h80) nx = 4;
         else if (a == 20'h00555 && d[7:0] == 8'h20) byp = 1'b1;
      3: fork run(0, a, d); join_none
      4: if (a == 20'h00555 && d[7:0] == 8'hAA) nx = 5;
      5: if (a == 20'h002AA && d[7:0] == 8'h55) nx = 7;
      6: if (d[7:0] == 8'h00) byp = 1'b0;
      7: if (d[7:0] == 8'h30) fork run(1, a, d); join_none
         else if (d[7:0] == 8'h10) fork run(2, a, d); join_none
    endcase
    step = nx;
  endtask

  // each write cycle with chip select low, out of reset and not busy latches address and data on its closing edge
  always @(posedge fl_we_n)
    if (!fl_ce_n && fl_reset_n && !busy)
      decode(fl_addr, data_bus_out);

  // hardware reset aborts and returns to array reads
  always @(negedge fl_reset_n)
  begin
    step = 0;
    busy = 1'b0;
  end

  // status bits while busy, array word otherwise
  always @(fl_addr or busy or pd7 or tgl)
    rd = busy ? {8'h00, pd7, tgl, 6'h00}
              : (mem.exists(fl_addr) ? mem[fl_addr] : 16'hFFFF);

  always @(negedge fl_oe_n)
    if (busy && !fl_ce_n)
      tgl = ~tgl;

  always @(rd or drv)
    if (drv)
      last = rd;
endmodule

/* File: testbench/bsfc_ctrl_test.sv */
// Purpose: self-checking bench of the flash controller
// Assumes: 25 MHz clk_sys, flash model with short operations
// Notes:   each register read leaves a note; the monitor compares those with a nonzero mask
`timescale 1ns/10ps
`include "bsfc_map.vh"

module bsfc_ctrl_test;
  logic        clk_sys = 1'b0;
  logic        sys_rst = 1'b1;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  wire         hreadyout, hresp, fl_byte_n, fl_ce_n, fl_we_n, fl_oe_n;
  wire         fl_reset_n, data_bus_oe, completion_indicator_n;
  wire  [31:0] hrdata;
  wire  [19:0] fl_addr;
  wire  [15:0] data_bus_out, data_bus_in;
  int          fail_count = 0;
  int          n_checks = 0;
  int          nwe = 0;
  logic        rd_ph = 1'b0;
  logic [31:0] exp_q[$];
  logic [31:0] msk_q[$];
  logic [31:0] r;
  logic [19:0] aa, ab;
  logic [15:0] da, db;

  bsfc_ctrl #(.POLL_MAX(32'd20)) dut_u (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .fl_addr(fl_addr), .fl_byte_n(fl_byte_n),
    .fl_ce_n(fl_ce_n), .fl_we_n(fl_we_n), .fl_oe_n(fl_oe_n),
    .fl_reset_n(fl_reset_n), .data_bus_out(data_bus_out),
    .data_bus_oe(data_bus_oe), .data_bus_in(data_bus_in),
    .completion_indicator_n(completion_indicator_n));

  bsfc_flash_model fm_u (
    .fl_addr(fl_addr), .fl_byte_n(fl_byte_n), .fl_ce_n(fl_ce_n),
    .fl_we_n(fl_we_n), .fl_oe_n(fl_oe_n), .fl_reset_n(fl_reset_n),
    .data_bus_out(data_bus_out), .data_bus_in(data_bus_in),
    .completion_indicator_n(completion_indicator_n));

  initial
  begin
    forever #20 clk_sys = ~clk_sys;
  end

  always @(negedge fl_we_n)
    nwe++;

  task automatic cmp(input string nm, input logic [31:0] e,
                     input logic [31:0] s, input logic [31:0] m);
    n_checks++;
    if (((s ^ e) & m) !== 32'h0)
    begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask

  // one single AHB transfer, read data left in r
  task automatic ahb(input logic [7:0] a, input logic w,
                     input logic [31:0] d);
    @(posedge clk_sys);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input logic [31:0] m);
    exp_q.push_back(e);
    msk_q.push_back(m);
    ahb(a, 1'b0, 32'h0);
  endtask

  // start an operation and poll until it reports done
  task automatic go(input logic [2:0] op, input logic [19:0] a,
                    input logic [15:0] d, input logic [7:0] fl);
    ahb(`BSFC_REG_ADDR, 1'b1, {12'h0, a});
    ahb(`BSFC_REG_WDATA, 1'b1, {16'h0, d});
    nwe = 0;
    ahb(`BSFC_REG_CTRL, 1'b1, {24'h0, fl | {4'h0, op, 1'b1}});
    do rd(`BSFC_REG_STATUS, 32'h0, 32'h0);
    while (r[`BSFC_ST_DONE] !== 1'b1 || r[`BSFC_ST_BUSY] !== 1'b0);
    rd(`BSFC_REG_STATUS, 32'h6, 32'h17);
  endtask

  task automatic rdback(input logic [19:0] a, input logic [15:0] e);
    go(`BSFC_OP_READ, a, 16'h0, 8'h00);
    rd(`BSFC_REG_RDATA, {16'h0, e}, 32'hFFFF);
  endtask

  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // result monitor: pops the oldest note at each read data phase
  always @(posedge clk_sys)
  begin
    if (rd_ph && exp_q.size() > 0)
    begin
      if (msk_q[0] != 32'h0)
        cmp("register read", exp_q[0], hrdata, msk_q[0]);
      void'(exp_q.pop_front());
      void'(msk_q.pop_front());
    end
    rd_ph <= hsel && htrans[1] && !hwrite && hreadyout;
  end

  initial
  begin
    #2000000;
    fail_count++;
    $display("watchdog expired");
    end_sim;
  end

  initial
  begin
    r = $urandom(32'hF79A);
    aa = {5'h01, 15'($urandom)};
    ab = {5'h02, 15'($urandom)};
    da = 16'($urandom);
    db = 16'($urandom);
    repeat (16) @(posedge clk_sys);
    sys_rst <= 1'b0;
    rd(`BSFC_REG_STATUS, 32'h4, 32'h1F);
    rd(8'h14, 32'h0, 32'hFFFFFFFF);
    $display("test reset state done");
    go(`BSFC_OP_PROG, aa, da, 8'h00);
    cmp("program writes", 32'd4, 32'(nwe), 32'hFF);
    rdback(aa, da);
    $display("test program done");
    go(`BSFC_OP_RAW, 20'h00555, 16'h00AA, 8'h00);
    go(`BSFC_OP_RAW, 20'h002AA, 16'h0055, 8'h00);
    go(`BSFC_OP_RAW, 20'h00555, 16'h0020, 8'h00);
    rd(`BSFC_REG_STATUS, 32'h8, 32'h8);
    go(`BSFC_OP_PROG, ab, db, 8'h20);
    cmp("bypass writes", 32'd2, 32'(nwe), 32'hFF);
    go(`BSFC_OP_UBEXIT, 20'h0, 16'h0, 8'h00);
    rd(`BSFC_REG_STATUS, 32'h0, 32'h8);
    rdback(ab, db);
    $display("test unlock bypass done");
    go(`BSFC_OP_SECT, aa, 16'h0, 8'h00);
    cmp("erase writes", 32'd6, 32'(nwe), 32'hFF);
    rdback(aa, 16'hFFFF);
    rdback(ab, db);
    $display("test sector erase done");
    go(`BSFC_OP_READ, ab, 16'h0, 8'h10);
    cmp("byte pin", 32'h0, {30'h0, hresp, fl_byte_n}, 32'h3);
    rd(`BSFC_REG_RDATA, {24'h0, db[7:0]}, 32'hFF);
    go(`BSFC_OP_CHIP, 20'h0, 16'h0, 8'h00);
    cmp("chip erase writes", 32'd6, 32'(nwe), 32'hFF);
    rdback(ab, 16'hFFFF);
    $display("test chip erase done");
    go(`BSFC_OP_SUSP, ab, 16'h0, 8'h0);
    go(`BSFC_OP_RESUME, ab, 16'h0, 8'h0);
    go(`BSFC_OP_RAW, 20'h00555, 16'h00AA, 8'h00);
    go(`BSFC_OP_RAW, 20'h002AA, 16'h0077, 8'h00);
    go(`BSFC_OP_PROG, ab, db, 8'h00);
    go(`BSFC_OP_READ, ab, 16'h0, 8'h80);
    rdback(ab, db);
    $display("test discard and flash reset done");
    ahb(`BSFC_REG_CTRL, 1'b1, 32'h40);
    rd(`BSFC_REG_CTRL, 32'h40, 32'h40);
    $display("test standby done");
    repeat (4) @(posedge clk_sys);
    end_sim;
  end
endmodule
